// ==== rtl/fcgc_consts.svh ====
`ifndef FCGC_CONSTS_SVH
`define FCGC_CONSTS_SVH

`define FCGC_CRC_W       32
`define FCGC_POLY        32'h04C11DB7
`define FCGC_PRESET      32'hFFFFFFFF
`define FCGC_RESIDUE     32'hC704DD7B
`define FCGC_CLK_NS      100
`define FCGC_IFS_NS      9600
`define FCGC_IFS_CYC     (`FCGC_IFS_NS / `FCGC_CLK_NS)

`endif

// ==== rtl/fcgc_pkg.sv ====
package fcgc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN  = 3'h2,
    ST_HOLD = 3'h4
  } fcgc_state_t;

  typedef struct packed {
    logic valid;
    logic mode;
    logic data;
  } fcgc_bit_t;

  typedef struct packed {
    logic done;
    logic error;
  } fcgc_verdict_t;

endpackage

// ==== rtl/fcgc_lfsr.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fcgc_consts.svh"

module fcgc_lfsr #(
  parameter int CRC_W = `FCGC_CRC_W
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             load_in,
  input  wire logic             shift_in,
  input  wire logic             mode_in,
  input  wire logic             data_in,
  output var  logic [CRC_W-1:0] crc_out,
  output var  logic             data_out
);

  localparam logic [CRC_W-1:0] POLY   = CRC_W'(`FCGC_POLY);
  localparam logic [CRC_W-1:0] PRESET = CRC_W'(`FCGC_PRESET);

  logic [CRC_W-1:0] crc_r;
  logic [CRC_W-1:0] crc_nxt;

  // shift step
  // Galois form, MSB first, so the x^31 term leaves first
  function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c,
                                                 input logic              d,
                                                 input logic              fb_on);
    logic fb;
    fb = fb_on & (c[CRC_W-1] ^ d);
    crc_step = {c[CRC_W-2:0], 1'b0} ^ (fb ? POLY : {CRC_W{1'b0}});
  endfunction

  always_comb
  begin
    crc_nxt = crc_r;
    if (load_in)
    begin
      crc_nxt = PRESET;
    end
    else if (shift_in)
    begin
      crc_nxt = crc_step(crc_r, data_in, mode_in);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      crc_r <= PRESET;
    end
    else
    begin
      crc_r <= crc_nxt;
    end
  end

  assign crc_out  = crc_r;
  assign data_out = mode_in ? data_in : ~crc_r[CRC_W-1];

endmodule // fcgc_lfsr

`default_nettype wire

// ==== rtl/fcgc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fcgc_consts.svh"

module fcgc_top #(
  parameter int CRC_W    = `FCGC_CRC_W,
  parameter bit LOW_PERF = 1'b0
) (
  input  wire logic REF_CLK_IN,
  input  wire logic RST_IN,
  input  wire logic INIT_IN,
  input  wire logic BIT_VALID_IN,
  input  wire logic MODE_IN,
  input  wire logic DATA_IN,
  input  wire logic FRAME_END_IN,
  input  wire logic BUF_FREE_IN,
  output var  logic DATA_OUT,
  output var  logic DATA_VALID_OUT,
  output var  logic CHECK_DONE_OUT,
  output var  logic CRC_ERR_OUT,
  output var  logic READY_OUT
);

  localparam logic [CRC_W-1:0] RESIDUE   = CRC_W'(`FCGC_RESIDUE);
  localparam logic [CRC_W-1:0] PRESET    = CRC_W'(`FCGC_PRESET);
  localparam logic [CRC_W-1:0] POLY      = CRC_W'(`FCGC_POLY);
  localparam int               RECOV_MAX = `FCGC_IFS_CYC;

  if (CRC_W != 32)
  begin : g_width_check
    $error("fcgc_top: only a 32-bit register is supported");
  end
  if (RECOV_MAX < 2)
  begin : g_recov_check
    $error("fcgc_top: clock too slow for the interframe recovery time");
  end

  fcgc_pkg::fcgc_state_t   state_r;
  fcgc_pkg::fcgc_state_t   state_nxt;
  fcgc_pkg::fcgc_bit_t     in_bit;
  fcgc_pkg::fcgc_bit_t     out_r;
  fcgc_pkg::fcgc_bit_t     out_nxt;
  fcgc_pkg::fcgc_verdict_t verdict_r;
  fcgc_pkg::fcgc_verdict_t verdict_nxt;
  logic                    ready_r;
  logic                    ready_nxt;
  logic                    accept_init;
  logic                    shift_en;
  logic [CRC_W-1:0]        crc;
  logic                    lfsr_dout;

  assign in_bit = '{valid: BIT_VALID_IN, mode: MODE_IN, data: DATA_IN};

  // buffer gate decode
  // Shared by the take decision and READY_OUT; READY_OUT is registered, so it lags a BUF_FREE_IN change by a cycle.
  function automatic logic frame_taken(input fcgc_pkg::fcgc_state_t st,
                                       input logic                  buf_free);
    frame_taken = (st != fcgc_pkg::ST_HOLD) || !LOW_PERF || buf_free;
  endfunction

  // low perf buffer gate
  // A full one-frame buffer blocks the next frame start; the frame is simply missed.
  assign accept_init = INIT_IN && frame_taken(state_r, BUF_FREE_IN);

  // init wins always
  // A preset taken in the same cycle as a bit drops that bit, so framing must not overlap them.
  assign shift_en = (state_r == fcgc_pkg::ST_RUN) && in_bit.valid && !INIT_IN;

  fcgc_lfsr #(
    .CRC_W (CRC_W)
  ) u_lfsr (
    .clk_in   (REF_CLK_IN),
    .rst_in   (RST_IN),
    .load_in  (accept_init),
    .shift_in (shift_en),
    .mode_in  (in_bit.mode),
    .data_in  (in_bit.data),
    .crc_out  (crc),
    .data_out (lfsr_dout)
  );

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      fcgc_pkg::ST_IDLE,
      fcgc_pkg::ST_HOLD:
      begin
        if (accept_init)
        begin
          state_nxt = fcgc_pkg::ST_RUN;
        end
      end
      fcgc_pkg::ST_RUN:
      begin
        if (accept_init)
        begin
          state_nxt = fcgc_pkg::ST_RUN;
        end
        else if (FRAME_END_IN)
        begin
          state_nxt = fcgc_pkg::ST_HOLD;
        end
      end
    endcase
  end

  always_comb
  begin
    out_nxt = '{valid: shift_en, mode: in_bit.mode, data: out_r.data};
    if (shift_en)
    begin
      out_nxt.data = lfsr_dout;
    end
  end

  always_comb
  begin
    verdict_nxt = verdict_r;
    if (accept_init)
    begin
      verdict_nxt = '{done: 1'b0, error: 1'b0};
    end
    else if ((state_r == fcgc_pkg::ST_RUN) && FRAME_END_IN)
    begin
      verdict_nxt = '{done: 1'b1, error: (crc != RESIDUE)};
    end
  end

  always_comb
  begin
    ready_nxt = frame_taken(state_nxt, BUF_FREE_IN);
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      state_r   <= fcgc_pkg::ST_IDLE;
      out_r     <= '0;
      verdict_r <= '0;
      ready_r   <= 1'b1;
    end
    else
    begin
      state_r   <= state_nxt;
      out_r     <= out_nxt;
      verdict_r <= verdict_nxt;
      ready_r   <= ready_nxt;
    end
  end

  assign DATA_OUT       = out_r.data;
  assign DATA_VALID_OUT = out_r.valid;
  assign CHECK_DONE_OUT = verdict_r.done;
  assign CRC_ERR_OUT    = verdict_r.error;
  assign READY_OUT      = ready_r;

  sequence s_fill;
    shift_en && in_bit.mode;
  endsequence

  sequence s_drain;
    shift_en && !in_bit.mode;
  endsequence

  sequence s_end;
    (state_r == fcgc_pkg::ST_RUN) && FRAME_END_IN && !INIT_IN;
  endsequence

  AST_PRESET: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    accept_init |=> (crc == PRESET) && (state_r == fcgc_pkg::ST_RUN) && !CHECK_DONE_OUT)
    else $error("register not preset to all ones on init");

  AST_PASS: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    s_fill |=> DATA_VALID_OUT && (DATA_OUT == $past(in_bit.data)))
    else $error("input bit not copied to output in fill mode");

  AST_DRAIN_INV: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    s_drain |=> DATA_VALID_OUT && (DATA_OUT == !$past(crc[CRC_W-1])))
    else $error("drain output is not the inverted top bit");

  AST_DRAIN_SHIFT: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    s_drain ##1 s_drain |=> crc == {$past(crc[CRC_W-3:0], 2), 2'b00})
    else $error("drain is not a plain shift toward x^31");

  AST_DIVIDE: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    s_fill |=> crc == ({$past(crc[CRC_W-2:0]), 1'b0} ^
                      (($past(crc[CRC_W-1]) ^ $past(in_bit.data)) ? POLY : '0)))
    else $error("register does not divide by the generator");

  AST_VERDICT: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    s_end |=> CHECK_DONE_OUT && (CRC_ERR_OUT == ($past(crc) != RESIDUE)))
    else $error("frame verdict does not match the residue compare");

  AST_HOLD: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    CHECK_DONE_OUT && !INIT_IN |=> CHECK_DONE_OUT && $stable(CRC_ERR_OUT))
    else $error("verdict changed before the next preset");

  AST_RECOVER: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    $rose(CHECK_DONE_OUT) && (!LOW_PERF || BUF_FREE_IN) |-> ##[0:RECOV_MAX] READY_OUT)
    else $error("not ready for a new frame within the interframe gap");

  AST_LOWPERF: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    (state_r == fcgc_pkg::ST_HOLD) && LOW_PERF && !BUF_FREE_IN && INIT_IN
      |=> (state_r == fcgc_pkg::ST_HOLD) && CHECK_DONE_OUT)
    else $error("frame taken while the buffer was full");

  // Low-performance station with its one-frame buffer still occupied
  sequence s_lp_full;
    (state_r == fcgc_pkg::ST_HOLD) && LOW_PERF && !BUF_FREE_IN;
  endsequence

  // Output bit only moves on an accepted strobe, so the framer may sample it late
  AST_OUT_HOLD: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    !shift_en |=> $stable(DATA_OUT) && !DATA_VALID_OUT)
    else $error("output bit moved without an accepted strobe");

  AST_VALID_CAUSE: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    DATA_VALID_OUT |-> $past(shift_en))
    else $error("output valid without a strobe one cycle earlier");

  AST_DRAIN_NOFB: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    s_drain |=> crc == {$past(crc[CRC_W-2:0]), 1'b0})
    else $error("feedback still active while draining");

  AST_CRC_IDLE: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    !accept_init && !shift_en |=> $stable(crc))
    else $error("register moved without a strobe or preset");

  // A bit that meets a preset is lost; the new frame must start clean
  AST_INIT_DROP: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    accept_init && in_bit.valid |=> !DATA_VALID_OUT && (crc == PRESET))
    else $error("bit taken in the same cycle as a preset");

  AST_STROBE_IDLE: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    in_bit.valid && (state_r != fcgc_pkg::ST_RUN) |=> !DATA_VALID_OUT)
    else $error("strobe accepted outside a frame");

  AST_FEND_IGNORED: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    FRAME_END_IN && (state_r != fcgc_pkg::ST_RUN) && !accept_init
      |=> $stable(CHECK_DONE_OUT) && $stable(CRC_ERR_OUT))
    else $error("stray frame end changed the verdict");

  AST_INIT_READY: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    accept_init |=> READY_OUT)
    else $error("not ready again right after a frame start");

  AST_HP_TAKE: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    (state_r == fcgc_pkg::ST_HOLD) && !LOW_PERF && INIT_IN
      |=> (state_r == fcgc_pkg::ST_RUN) && !CHECK_DONE_OUT)
    else $error("frame refused right after the previous one");

  AST_READY_LP: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    s_lp_full |=> !READY_OUT)
    else $error("ready shown while the buffer is full");

  AST_LP_HOLD_ERR: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    s_lp_full ##0 INIT_IN |=> $stable(CRC_ERR_OUT))
    else $error("refused frame disturbed the verdict");

  // Freeing the buffer must let the very next start through
  AST_LP_RESUME: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    (state_r == fcgc_pkg::ST_HOLD) && BUF_FREE_IN && INIT_IN
      |=> (state_r == fcgc_pkg::ST_RUN) && READY_OUT)
    else $error("frame refused although the buffer is free");

endmodule // fcgc_top

`default_nettype wire

// ==== dv/fcgc_framer_bfm.sv ====
`timescale 1ns/1ps
`default_nettype none

module fcgc_framer_bfm (
  input  wire logic clk_in,
  input  wire logic q_in,
  input  wire logic v_in,
  output var  logic init_out,
  output var  logic valid_out,
  output var  logic mode_out,
  output var  logic data_out,
  output var  logic fend_out
);
  initial
  begin
    init_out = 1'b0;
    valid_out = 1'b0;
    mode_out = 1'b1;
    data_out = 1'b0;
    fend_out = 1'b0;
  end

  task automatic pulse_init();
    @(posedge clk_in);
    init_out <= 1'b1;
    @(posedge clk_in);
    init_out <= 1'b0;
  endtask

  task automatic put_bit(input logic m, input logic d, output logic q, output logic v);
    @(posedge clk_in);
    valid_out <= 1'b1;
    mode_out <= m;
    data_out <= d;
    @(posedge clk_in);
    valid_out <= 1'b0;
    // Released line flips so a stale bit is never read as fresh
    data_out <= ~d;
    @(negedge clk_in);
    q = q_in;
    v = v_in;
  endtask

  task automatic end_frame();
    @(posedge clk_in);
    fend_out <= 1'b1;
    @(posedge clk_in);
    fend_out <= 1'b0;
  endtask
endmodule // fcgc_framer_bfm

`default_nettype wire

// ==== dv/tb_frame_crc32_gen_check.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fcgc_consts.svh"

module tb_frame_crc32_gen_check;
  logic        clk;
  logic        rst;
  logic        init;
  logic        vld;
  logic        mode;
  logic        dat;
  logic        fend;
  logic        buf_free;
  logic        q;
  logic        qv;
  logic        done;
  logic        err;
  logic        rdy;
  logic        lp_done;
  logic        lp_err;
  logic        lp_rdy;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [31:0] rs = 32'h68968846;

  fcgc_top dut (.REF_CLK_IN(clk), .RST_IN(rst), .INIT_IN(init), .BIT_VALID_IN(vld),
    .MODE_IN(mode), .DATA_IN(dat), .FRAME_END_IN(fend), .BUF_FREE_IN(buf_free),
    .DATA_OUT(q), .DATA_VALID_OUT(qv), .CHECK_DONE_OUT(done), .CRC_ERR_OUT(err),
    .READY_OUT(rdy));

  // Low-performance build on the same stimulus; only its frame gate differs
  fcgc_top #(.LOW_PERF(1'b1)) dut_lp (.REF_CLK_IN(clk), .RST_IN(rst), .INIT_IN(init),
    .BIT_VALID_IN(vld), .MODE_IN(mode), .DATA_IN(dat), .FRAME_END_IN(fend),
    .BUF_FREE_IN(buf_free), .DATA_OUT(), .DATA_VALID_OUT(), .CHECK_DONE_OUT(lp_done),
    .CRC_ERR_OUT(lp_err), .READY_OUT(lp_rdy));

  fcgc_framer_bfm bfm (.clk_in(clk), .q_in(q), .v_in(qv), .init_out(init),
    .valid_out(vld), .mode_out(mode), .data_out(dat), .fend_out(fend));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b);
    return {c[30:0], 1'b0} ^ ((c[31] ^ b) ? `FCGC_POLY : 32'h0);
  endfunction

  task automatic chk(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic frame(input int n, input bit tx, input bit flip, input string name);
    logic [31:0] c;
    logic        b;
    logic        o;
    logic        v;
    c = `FCGC_PRESET;
    chk(rdy, 1'b1, "ready");
    chk(lp_rdy, 1'b1, "lp ready");
    bfm.pulse_init();
    for (int i = 0; i < n; i++)
    begin
      rs = xs(rs);
      b = rs[0];
      c = crc_step(c, b);
      bfm.put_bit(1'b1, b, o, v);
      chk(v, 1'b1, "valid");
      chk(o, b, "pass");
    end
    for (int i = 0; i < 32; i++)
    begin
      rs = xs(rs);
      // Random input during drain proves feedback is off
      if (tx)
        bfm.put_bit(1'b0, rs[0], o, v);
      else
        bfm.put_bit(1'b1, ~c[31-i] ^ (flip && i == 7), o, v);
      if (tx)
        chk(o, ~c[31-i], "fcs");
      else
        chk(o, ~c[31-i] ^ (flip && i == 7), "rx pass");
    end
    bfm.end_frame();
    @(negedge clk);
    chk(done, 1'b1, "done");
    chk(lp_done, 1'b1, "lp done");
    if (!tx)
    begin
      chk(err, flip, "verdict");
      chk(lp_err, flip, "lp verdict");
    end
    bfm.put_bit(1'b1, 1'b1, o, v);
    chk(v, 1'b0, "refused");
    chk(done, 1'b1, "held");
    if (!tx)
      chk(err, flip, "held err");
    $display("test %s finished", name);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 8000)
    begin
      n_fail++;
      conclude();
    end
  end

  initial
  begin
    rst = 1'b1;
    buf_free = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(done, 1'b0, "reset done");
    frame(16, 1'b1, 1'b0, "tx");
    frame(24, 1'b0, 1'b0, "rx after tx");
    frame(40, 1'b0, 1'b1, "rx bad");
    frame(1, 1'b0, 1'b0, "rx short");
    // Full buffer: only the low-performance build refuses the next start
    @(posedge clk);
    buf_free <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(lp_rdy, 1'b0, "lp busy");
    chk(rdy, 1'b1, "hp ready");
    bfm.pulse_init();
    @(negedge clk);
    chk(lp_done, 1'b1, "lp kept");
    chk(done, 1'b0, "hp took");
    @(posedge clk);
    buf_free <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(lp_rdy, 1'b1, "lp free");
    $display("test lowperf finished");
    for (int k = 0; k < 4; k++)
    begin
      rs = xs(rs);
      frame(8 + int'(rs[5:0]), rs[7], rs[6], "random");
    end
    conclude();
  end
endmodule // tb_frame_crc32_gen_check

`default_nettype wire
